// ===== lat_regs.svh
// Register offsets, field positions, reset values and timing figures
// for the left AGC timing configuration bank.
// Assumes the includer wraps nothing around it; definitions only.
`ifndef LAT_REGS_SVH
`define LAT_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LAT_PAGE           8'h00
`define LAT_ATTACK_IDX     8'h67
`define LAT_DECAY_IDX      8'h68
`define LAT_TIMING_RST     8'h00
`define LAT_UNMAPPED_RD    8'h00
`define LAT_TIME_RST       16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LAT_SEL_BIT        7
`define LAT_BASE_HI        6
`define LAT_BASE_LO        5
`define LAT_MULT_HI        4
`define LAT_MULT_LO        2

// ----------------------------------------------------------------
// Baseline times in ms
// ----------------------------------------------------------------
`define LAT_ATT_00_MS      16'h0007
`define LAT_ATT_01_MS      16'h0008
`define LAT_ATT_10_MS      16'h000a
`define LAT_ATT_11_MS      16'h000b
`define LAT_DEC_00_MS      16'h0032
`define LAT_DEC_01_MS      16'h0096
`define LAT_DEC_10_MS      16'h00fa
`define LAT_DEC_11_MS      16'h015e

// ----------------------------------------------------------------
// Decay caps in ms, per decimation ratio
// ----------------------------------------------------------------
`define LAT_CAP_1_MS       16'h0fa0
`define LAT_CAP_1P5_MS     16'h15e0
`define LAT_CAP_2_MS       16'h1f40
`define LAT_CAP_2P5_MS     16'h2580
`define LAT_CAP_3_MS       16'h2bc0
`define LAT_CAP_4_MS       16'h3e80
`define LAT_CAP_5_MS       16'h4b00
`define LAT_CAP_5P5_MS     16'h5780

`endif

// ===== lat_pkg.sv
// Types shared by the left AGC timing configuration bank.
// Assumes lat_regs.svh supplies the numeric constants.
package lat_pkg;

	// Time in milliseconds
	typedef logic [15:0] lat_ms_t;

	// Half-step decimation ratio code, twice the ratio
	typedef logic [3:0]  lat_ratio_t;

	// Timing source of one AGC time
	typedef enum logic {
		LAT_SRC_LEGACY,
		LAT_SRC_REG
	} lat_src_t;

endpackage

// ===== lat_config.sv
// Left AGC attack and decay timing registers with decode to effective times.
// Assumes a synchronous register port from the control bus front end
// and legacy times and decimation ratio supplied by the codec core.
`timescale 1ns/1ps
`include "lat_regs.svh"

module lat_config (
	// Clock and reset
	input  wire logic               CLOCK_I,
	input  wire logic               RSTN_I,
	// Register port
	input  wire logic [7:0]         REG_PAGE_I,
	input  wire logic [7:0]         REG_ADDR_I,
	input  wire logic               REG_WE_I,
	input  wire logic [7:0]         REG_WDATA_I,
	input  wire logic               REG_RE_I,
	output logic      [7:0]         REG_RDATA_O,
	output logic                    REG_RVALID_O,
	// Codec core side
	input  wire lat_pkg::lat_ms_t   LEGACY_ATTACK_MS_I,
	input  wire lat_pkg::lat_ms_t   LEGACY_DECAY_MS_I,
	input  wire lat_pkg::lat_ratio_t ADC_DECIMATION_RATIO_I,
	// Effective times to the gain engine
	output lat_pkg::lat_ms_t        ATTACK_MS_O,
	output lat_pkg::lat_ms_t        DECAY_MS_O
);

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------

	// Attack baseline from the two-bit code
	function automatic lat_pkg::lat_ms_t att_base(input logic [1:0] code);
		case (code)
			2'h0:    att_base = `LAT_ATT_00_MS;
			2'h1:    att_base = `LAT_ATT_01_MS;
			2'h2:    att_base = `LAT_ATT_10_MS;
			default: att_base = `LAT_ATT_11_MS;
		endcase
	endfunction

	// Decay baseline from the two-bit code
	function automatic lat_pkg::lat_ms_t dec_base(input logic [1:0] code);
		case (code)
			2'h0:    dec_base = `LAT_DEC_00_MS;
			2'h1:    dec_base = `LAT_DEC_01_MS;
			2'h2:    dec_base = `LAT_DEC_10_MS;
			default: dec_base = `LAT_DEC_11_MS;
		endcase
	endfunction

	// Baseline times two to the multiplier code; 350 ms x 128 fits 16 bits
	function automatic lat_pkg::lat_ms_t scale(input lat_pkg::lat_ms_t base,
	                                           input logic [2:0] mult);
		scale = base << mult;
	endfunction

	// Decay cap from the half-step ratio code; out-of-range codes clamp
	function automatic lat_pkg::lat_ms_t dec_cap(input lat_pkg::lat_ratio_t r);
		case (r)
			4'h0, 4'h1, 4'h2: dec_cap = `LAT_CAP_1_MS;
			4'h3:             dec_cap = `LAT_CAP_1P5_MS;
			4'h4:             dec_cap = `LAT_CAP_2_MS;
			4'h5:             dec_cap = `LAT_CAP_2P5_MS;
			4'h6, 4'h7:       dec_cap = `LAT_CAP_3_MS;
			4'h8, 4'h9:       dec_cap = `LAT_CAP_4_MS;
			4'ha:             dec_cap = `LAT_CAP_5_MS;
			default:          dec_cap = `LAT_CAP_5P5_MS;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0]        attack_q;
	logic [7:0]        decay_q;
	logic              hit_page;
	lat_pkg::lat_src_t att_src;
	lat_pkg::lat_src_t dec_src;
	lat_pkg::lat_ms_t  att_d;
	lat_pkg::lat_ms_t  dec_raw;
	lat_pkg::lat_ms_t  dec_lim;
	lat_pkg::lat_ms_t  dec_d;

	assign hit_page = (REG_PAGE_I == `LAT_PAGE);

	// Attack timing register write; whole byte stored as written
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			attack_q <= `LAT_TIMING_RST;
		end else if (REG_WE_I && hit_page && REG_ADDR_I == `LAT_ATTACK_IDX) begin
			attack_q <= REG_WDATA_I;
		end
	end

	// Decay timing register write, next index after attack
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			decay_q <= `LAT_TIMING_RST;
		end else if (REG_WE_I && hit_page && REG_ADDR_I == `LAT_DECAY_IDX) begin
			decay_q <= REG_WDATA_I;
		end
	end

	// Readback one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			REG_RDATA_O  <= `LAT_UNMAPPED_RD;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RE_I;
			if (!REG_RE_I) begin
				REG_RDATA_O <= REG_RDATA_O;
			end else if (hit_page && REG_ADDR_I == `LAT_ATTACK_IDX) begin
				REG_RDATA_O <= attack_q;
			end else if (hit_page && REG_ADDR_I == `LAT_DECAY_IDX) begin
				REG_RDATA_O <= decay_q;
			end else begin
				REG_RDATA_O <= `LAT_UNMAPPED_RD;
			end
		end
	end

	// ----------------------------------------------------------------
	// Effective time selection
	// ----------------------------------------------------------------

	// Source selects
	assign att_src = attack_q[`LAT_SEL_BIT] ? lat_pkg::LAT_SRC_REG : lat_pkg::LAT_SRC_LEGACY;
	assign dec_src = decay_q[`LAT_SEL_BIT] ? lat_pkg::LAT_SRC_REG : lat_pkg::LAT_SRC_LEGACY;

	// Attack time from legacy input or own fields
	always_comb begin
		case (att_src)
			lat_pkg::LAT_SRC_REG: att_d = scale(att_base(attack_q[`LAT_BASE_HI:`LAT_BASE_LO]),
			                                    attack_q[`LAT_MULT_HI:`LAT_MULT_LO]);
			default:              att_d = LEGACY_ATTACK_MS_I;
		endcase
	end

	// Decay time from legacy input or own fields, then capped
	always_comb begin
		case (dec_src)
			lat_pkg::LAT_SRC_REG: dec_raw = scale(dec_base(decay_q[`LAT_BASE_HI:`LAT_BASE_LO]),
			                                      decay_q[`LAT_MULT_HI:`LAT_MULT_LO]);
			default:              dec_raw = LEGACY_DECAY_MS_I;
		endcase
		dec_lim = dec_cap(ADC_DECIMATION_RATIO_I);
		dec_d   = (dec_raw > dec_lim) ? dec_lim : dec_raw;
	end

	// Registered effective times
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ATTACK_MS_O <= `LAT_TIME_RST;
			DECAY_MS_O  <= `LAT_TIME_RST;
		end else begin
			ATTACK_MS_O <= att_d;
			DECAY_MS_O  <= dec_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	chk_attack_legacy: assert property (
		!attack_q[7] |=> ATTACK_MS_O == $past(LEGACY_ATTACK_MS_I))
		else $error("attack time not taken from legacy source");

	chk_attack_base: assert property (
		attack_q[7:2] == 6'h20 ##0 attack_q[7:2] == 6'h20 |=> ATTACK_MS_O == 16'h0007)
		else $error("attack baseline 00 not 7 ms");

	chk_attack_mult: assert property (
		attack_q[7:2] == 6'h3f |=> ATTACK_MS_O == 16'h0580)
		else $error("attack 11 ms times 128 not 1408 ms");

	chk_attack_mult_mid: assert property (
		attack_q[7:2] == 6'h2f |=> ATTACK_MS_O == 16'h0400)
		else $error("attack 8 ms times 128 not 1024 ms");

	chk_decay_legacy: assert property (
		!decay_q[7] && ADC_DECIMATION_RATIO_I == 4'hc && LEGACY_DECAY_MS_I < 16'h5780
		|=> DECAY_MS_O == $past(LEGACY_DECAY_MS_I))
		else $error("decay time not taken from legacy source");

	chk_decay_base: assert property (
		decay_q[7:2] == 6'h38 |=> DECAY_MS_O == 16'h015e)
		else $error("decay baseline 11 not 350 ms");

	chk_decay_mult: assert property (
		decay_q[7:2] == 6'h27 && ADC_DECIMATION_RATIO_I == 4'hc |=> DECAY_MS_O == 16'h1900)
		else $error("decay 50 ms times 128 not 6400 ms");

	chk_decay_cap: assert property (
		decay_q[7:2] == 6'h3f && ADC_DECIMATION_RATIO_I == 4'h2 |=> DECAY_MS_O == 16'h0fa0)
		else $error("decay not capped at 4 s for ratio 1");

	chk_attack_base_hi: assert property (
		attack_q[7:2] == 6'h30 |=> ATTACK_MS_O == 16'h000a)
		else $error("attack baseline 10 not 10 ms");

	chk_attack_mult_low: assert property (
		attack_q[7:2] == 6'h21 |=> ATTACK_MS_O == 16'h000e)
		else $error("attack 7 ms times 2 not 14 ms");

	chk_decay_base_mid: assert property (
		decay_q[7:2] == 6'h28 |=> DECAY_MS_O == 16'h0096)
		else $error("decay baseline 01 not 150 ms");

	chk_decay_cap_max: assert property (
		DECAY_MS_O <= 16'h5780)
		else $error("decay time above the 22.4 s ceiling");

	chk_decay_read: assert property (
		REG_WE_I && REG_PAGE_I == 8'h00 && REG_ADDR_I == 8'h68 ##1
		REG_RE_I && !REG_WE_I && REG_PAGE_I == 8'h00 && REG_ADDR_I == 8'h68
		|=> REG_RVALID_O && REG_RDATA_O == $past(REG_WDATA_I, 2))
		else $error("decay register at index 104 not read back");

	chk_write_to_time: assert property (
		REG_WE_I && REG_PAGE_I == 8'h00 && REG_ADDR_I == 8'h67 && REG_WDATA_I == 8'hb4
		|=> ##1 ATTACK_MS_O == 16'h0100)
		else $error("attack write not reflected two cycles later");

endmodule // lat_config

// ===== tb_top.sv
// Self-checking bench for the left AGC timing configuration bank.
// Assumes lat_pkg and lat_config are compiled first; one clock, no partner.
`timescale 1ns/1ps

module tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                clk;
	logic                rstn;
	logic [7:0]          pg;
	logic [7:0]          addr;
	logic [7:0]          wdata;
	logic                we;
	logic                re;
	logic [7:0]          rdata;
	logic                rvalid;
	lat_pkg::lat_ms_t    leg_att;
	lat_pkg::lat_ms_t    leg_dec;
	lat_pkg::lat_ms_t    att;
	lat_pkg::lat_ms_t    dec;
	lat_pkg::lat_ratio_t ratio;
	int                  n_mismatch = 0;
	int                  n_checks = 0;
	int                  cycles = 0;
	logic [15:0]         att_base [4] = '{16'h0007, 16'h0008, 16'h000a, 16'h000b};
	logic [15:0]         dec_base [4] = '{16'h0032, 16'h0096, 16'h00fa, 16'h015e};

	lat_config uut (
		.CLOCK_I(clk), .RSTN_I(rstn), .REG_PAGE_I(pg), .REG_ADDR_I(addr), .REG_WE_I(we),
		.REG_WDATA_I(wdata), .REG_RE_I(re), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.LEGACY_ATTACK_MS_I(leg_att), .LEGACY_DECAY_MS_I(leg_dec),
		.ADC_DECIMATION_RATIO_I(ratio), .ATTACK_MS_O(att), .DECAY_MS_O(dec));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// Decay ceiling per ratio code (twice the ratio)
	function automatic logic [15:0] cap_of(input logic [3:0] r);
		case (r)
			4'h3: cap_of = 16'h15e0;
			4'h4: cap_of = 16'h1f40;
			4'h5: cap_of = 16'h2580;
			4'h6, 4'h7: cap_of = 16'h2bc0;
			4'h8, 4'h9: cap_of = 16'h3e80;
			4'ha: cap_of = 16'h4b00;
			4'hb, 4'hc: cap_of = 16'h5780;
			default: cap_of = 16'h0fa0;
		endcase
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		we = 1'b0;
	endtask

	// Read, then judge valid pulse and data one edge later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		re = 1'b1;
		addr = a;
		@(negedge clk);
		re = 1'b0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	task automatic end_of_test();
		$display("n_checks=%0d n_mismatch=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(8'h67, 8'h00);
		rd(8'h68, 8'h00);
	endtask

	task automatic t_legacy();
		leg_att = 16'h1234;
		leg_dec = 16'h0abc;
		settle();
		chk(att, 16'h1234);
		chk(dec, 16'h0abc);
		leg_dec = 16'hffff;
		settle();
		chk(dec, cap_of(ratio));
	endtask

	task automatic t_attack();
		for (int b = 0; b < 4; b++) begin
			for (int m = 0; m < 8; m++) begin
				wr(8'h67, {1'b1, b[1:0], m[2:0], 2'b00});
				settle();
				chk(att, att_base[b] << m);
			end
		end
		rd(8'h67, 8'hfc);
		wr(8'h67, 8'h7c);
		settle();
		chk(att, leg_att);
	endtask

	task automatic t_decay();
		logic [15:0] e;
		for (int b = 0; b < 4; b++) begin
			for (int m = 0; m < 8; m++) begin
				e = dec_base[b] << m;
				if (e > cap_of(ratio))
					e = cap_of(ratio);
				wr(8'h68, {1'b1, b[1:0], m[2:0], 2'b00});
				settle();
				chk(dec, e);
			end
		end
	endtask

	// Longest programmed decay against every ratio ceiling
	task automatic t_cap();
		wr(8'h68, 8'hfc);
		for (int r = 0; r < 13; r++) begin
			ratio = r[3:0];
			settle();
			chk(dec, cap_of(ratio));
		end
	endtask

	// Other page and neighbour index stay unmapped
	task automatic t_map();
		pg = 8'h01;
		wr(8'h68, 8'h00);
		rd(8'h68, 8'h00);
		pg = 8'h00;
		rd(8'h68, 8'hfc);
		rd(8'h69, 8'h00);
	endtask

	// Decay write followed at once by its readback
	task automatic t_b2b();
		@(negedge clk);
		we = 1'b1;
		addr = 8'h68;
		wdata = 8'h9c;
		@(negedge clk);
		we = 1'b0;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk({8'h00, rdata}, 16'h009c);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		pg = 8'h00;
		addr = 8'h00;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
		leg_att = 16'h0000;
		leg_dec = 16'h0000;
		ratio = 4'hc;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_legacy();
		t_attack();
		t_decay();
		t_cap();
		t_map();
		t_b2b();
		end_of_test();
	end
endmodule // tb_top
